// file: ivfm_pkg.sv
// Constants, types and decoding helpers of the input voltage fault monitor.
// Assumes a single 50 MHz clock and measured input voltage in 1/256 V units.
// Notes on behaviour
// - Overvoltage fault when input reaches limit 55h.
// - Limit words: exponent 15:11, mantissa 10:0.
// - Overvoltage limit 4 V to 20 V, 0.25-V steps.
// - Power cycle or store/restore rounds limit.
// - Unsupported writes rejected, flagged, host notified; 58h writes to an out-of-range phase are dropped unflagged.
// - Overvoltage sets summary, input and overvoltage flags.
// - Response 00b keeps switching through fault.
// - Response 01b switches delay cycles, then shuts.
// - Response 10b shuts at once; 11b invalid.
// - Retry code zero latches off after shutdown.
// - Retry 1-6: hiccup, restart that many times.
// - Attempts during overvoltage still use retry budget.
// - Retry 7 restarts forever until off or success.
// - Delay codes 0,1: one clock, one rise.
// - Codes 2-4 three clocks; 5-7 seven clocks.
// - Ignore response with fault at enable: no start.
// - Undervoltage warning when input falls to 58h.
// - Undervoltage limit and warning kept per phase.
// - Warning sets summary, input and warning flags.
// - Undervoltage limit 2.5 V to 15.5 V on writes; NVM reload unchecked.
package ivfm_pkg;

    // ------------------------------------------------------------------
    // Command codes and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_OV_LIMIT    = 8'h55;
    localparam logic [7:0] CMD_OV_RESPONSE = 8'h56;
    localparam logic [7:0] CMD_UV_LIMIT    = 8'h58;
    localparam int         EXP_MSB         = 15;
    localparam int         EXP_LSB         = 11;
    localparam int         MAN_MSB         = 10;
    localparam logic [4:0] EXP_RESET       = 5'h1e;
    localparam logic [1:0] ACT_IGNORE      = 2'h0;
    localparam logic [1:0] ACT_DELAYED     = 2'h1;
    localparam logic [1:0] ACT_IMMEDIATE   = 2'h2;
    localparam logic [1:0] ACT_INVALID     = 2'h3;
    localparam logic [2:0] RETRY_LATCH     = 3'h0;
    localparam logic [2:0] RETRY_FOREVER   = 3'h7;

    // ------------------------------------------------------------------
    // Voltage scaling: fixed point with eight fraction bits
    // ------------------------------------------------------------------
    localparam int                 FRAC        = 8;
    localparam int                 STEP_BITS   = 6;
    localparam logic signed [31:0] STEP_HALF   = 32'sh20;
    localparam logic signed [31:0] LIN_SAT     = 32'sh7fffffff;
    localparam logic signed [31:0] OV_MIN_FIX  = 32'sh400;
    localparam logic signed [31:0] OV_MAX_FIX  = 32'sh1400;
    localparam logic signed [31:0] UV_MIN_FIX  = 32'sh280;
    localparam logic signed [31:0] UV_MAX_FIX  = 32'sh0f80;
    localparam logic [2:0]         DLY_ONE     = 3'h1;
    localparam logic [2:0]         DLY_THREE   = 3'h3;
    localparam logic [2:0]         DLY_SEVEN   = 3'h7;
    localparam logic [2:0]         DLY_CODE_HI = 3'h4;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] wdata;
    } ivfm_cmd_t;

    typedef struct packed {
        logic nota;
        logic input_word;
        logic input_overvoltage_flag;
        logic invalid_data;
    } ivfm_status_t;

    // Decodes a linear word into fixed point volts.
    function automatic logic signed [31:0] ivfm_lin_to_fix(
        input logic [15:0] w);
        logic signed [4:0]  e;
        logic signed [10:0] m;
        logic signed [31:0] mx;
        int                 sh;
        e  = w[EXP_MSB:EXP_LSB];
        m  = w[MAN_MSB:0];
        mx = 32'(m);
        sh = int'(e) + FRAC;
        if (sh > FRAC) begin
            ivfm_lin_to_fix = (m < 0) ? -LIN_SAT : LIN_SAT;
        end else if (sh >= 0) begin
            ivfm_lin_to_fix = mx <<< sh;
        end else begin
            ivfm_lin_to_fix = mx >>> (-sh);
        end
    endfunction

    // Rounds an overvoltage limit to the nearest supported value.
    function automatic logic [15:0] ivfm_round_ov(input logic [15:0] w);
        logic signed [31:0] q;
        q = (ivfm_lin_to_fix(w) + STEP_HALF) >>> STEP_BITS;
        if (q < (OV_MIN_FIX >>> STEP_BITS)) q = OV_MIN_FIX >>> STEP_BITS;
        if (q > (OV_MAX_FIX >>> STEP_BITS)) q = OV_MAX_FIX >>> STEP_BITS;
        ivfm_round_ov = {EXP_RESET, q[MAN_MSB:0]};
    endfunction

    // Shutdown delay in PWM clocks for a delay code.
    function automatic logic [2:0] ivfm_dly_clocks(input logic [2:0] c);
        if (c <= DLY_ONE) ivfm_dly_clocks = DLY_ONE;
        else if (c <= DLY_CODE_HI) ivfm_dly_clocks = DLY_THREE;
        else ivfm_dly_clocks = DLY_SEVEN;
    endfunction

    // Hiccup length in rise times for a delay code.
    function automatic logic [2:0] ivfm_hiccup_mult(input logic [2:0] c);
        ivfm_hiccup_mult = (c <= DLY_ONE) ? DLY_ONE : c;
    endfunction

endpackage

// file: ivfm_sync3.sv
// Three-stage synchroniser for an input from outside the clock domain.
// The output changes only once the second and third stages agree.
`timescale 1ns/1ps
module ivfm_sync3 (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic q_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_reg  <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) q_reg <= s3_reg;
        end
    end

    assign q = q_reg;
endmodule

// file: ivfm_monitor.sv
// Input overvoltage fault response and per-phase undervoltage warning.
// Assumes commands arrive decoded from the PMBus layer, one per cycle,
// and voltages come from telemetry on the same clock.
`timescale 1ns/1ps
module ivfm_monitor
    import ivfm_pkg::*;
#(
    parameter int PHASES = 2,
    parameter int VIN_W  = 24,
    parameter int RISE_W = 24
) (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          pwm_clk,
    input  wire ivfm_cmd_t                     cmd,
    input  wire logic [$clog2(PHASES+1)-1:0]   cmd_phase,
    output logic                               rsp_valid,
    output logic [15:0]                        rsp_rdata,
    input  wire logic [PHASES-1:0][VIN_W-1:0]  power_input_voltage,
    input  wire logic                          enable,
    input  wire logic [RISE_W-1:0]             rise_time_cycles,
    input  wire logic                          nvm_restore,
    input  wire logic                          nvm_store,
    input  wire logic [10:0]                   nvm_ov_mantissa,
    input  wire logic [10:0]                   nvm_uv_mantissa,
    input  wire logic [7:0]                    nvm_policy,
    input  wire logic                          clear_faults,
    output logic                               switching,
    output logic                               latched_off,
    output ivfm_status_t                       status,
    output logic [PHASES-1:0]                  input_undervoltage_warning_flag,
    output logic                               alert_n
);
    // ------------------------------------------------------------------
    // Registers and PWM clock edge detection
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_RUN    = 5'h02,
        ST_DELAY  = 5'h04,
        ST_HICCUP = 5'h08,
        ST_LATCH  = 5'h10
    } ivfm_state_t;

    ivfm_state_t              state_reg, state_next;
    logic [15:0]              ov_limit_reg;
    logic [7:0]               policy_reg;
    logic [PHASES-1:0][15:0]  uv_limit_reg;
    logic                     load_pending_reg;
    ivfm_status_t             status_reg;
    logic [PHASES-1:0]        uvw_reg;
    logic [15:0]              rdata_reg;
    logic                     rvalid_reg;
    logic [2:0]               delay_cnt_reg, delay_cnt_next;
    logic [RISE_W-1:0]        rise_cnt_reg, rise_cnt_next;
    logic [2:0]               mult_cnt_reg, mult_cnt_next;
    logic [2:0]               budget_reg, budget_next;
    logic                     pwm_sync;
    logic                     pwm_last_reg;

    ivfm_sync3 u_pwm_sync (
        .clock (clock),
        .rst   (rst),
        .d     (pwm_clk),
        .q     (pwm_sync)
    );

    wire pwm_tick = pwm_sync & ~pwm_last_reg;

    // ------------------------------------------------------------------
    // Field decode and comparisons
    // ------------------------------------------------------------------
    wire [1:0] ov_action_select = policy_reg[7:6];
    wire [2:0] ov_restart_count = policy_reg[5:3];
    wire [2:0] ov_delay_select  = policy_reg[2:0];
    wire [4:0] ov_limit_exponent = ov_limit_reg[EXP_MSB:EXP_LSB];
    wire [10:0] ov_limit_mantissa = ov_limit_reg[MAN_MSB:0];

    wire signed [31:0] ov_fix = ivfm_lin_to_fix(ov_limit_reg);
    wire signed [31:0] vin0   = 32'(power_input_voltage[0]);
    wire ov_fault = (vin0 >= ov_fix);

    logic [PHASES-1:0] uv_cond;
    genvar gp;
    generate
        for (gp = 0; gp < PHASES; gp++) begin : g_uv
            wire signed [31:0] uv_fix = ivfm_lin_to_fix(uv_limit_reg[gp]);
            wire signed [31:0] vin_p  = 32'(power_input_voltage[gp]);
            assign uv_cond[gp] = (vin_p <= uv_fix);
        end
    endgenerate

    wire signed [31:0] wr_fix = ivfm_lin_to_fix(cmd.wdata);
    wire ov_wr_ok = (wr_fix >= OV_MIN_FIX) && (wr_fix <= OV_MAX_FIX)
                  && (wr_fix[STEP_BITS-1:0] == '0);
    wire uv_wr_ok = (wr_fix >= UV_MIN_FIX) && (wr_fix <= UV_MAX_FIX);
    wire pol_wr_ok = (cmd.wdata[7:6] != ACT_INVALID);
    wire phase_ok  = (int'(cmd_phase) < PHASES);
    wire wr_ov  = cmd.wr && (cmd.code == CMD_OV_LIMIT);
    wire wr_pol = cmd.wr && (cmd.code == CMD_OV_RESPONSE);
    wire wr_uv  = cmd.wr && (cmd.code == CMD_UV_LIMIT) && phase_ok;
    wire bad_write = (wr_ov && !ov_wr_ok) || (wr_pol && !pol_wr_ok)
                   || (wr_uv && !uv_wr_ok);

    wire [RISE_W-1:0] rise_load = (rise_time_cycles == '0) ? '0
                                : rise_time_cycles - RISE_W'(1);
    wire budget_full = (ov_restart_count == RETRY_FOREVER);

    // ------------------------------------------------------------------
    // Fault response state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        delay_cnt_next = delay_cnt_reg;
        rise_cnt_next  = rise_cnt_reg;
        mult_cnt_next  = mult_cnt_reg;
        budget_next    = budget_reg;
        case (state_reg)
            ST_IDLE: begin
                budget_next = ov_restart_count;
                if (enable && !ov_fault) state_next = ST_RUN;
            end
            ST_RUN: begin
                budget_next = ov_restart_count;
                if (!enable) begin
                    state_next = ST_IDLE;
                end else if (ov_fault) begin
                    if (ov_action_select == ACT_DELAYED) begin
                        state_next     = ST_DELAY;
                        delay_cnt_next = ivfm_dly_clocks(ov_delay_select);
                    end else if (ov_action_select != ACT_IGNORE) begin
                        state_next = (ov_restart_count == RETRY_LATCH)
                                   ? ST_LATCH : ST_HICCUP;
                        rise_cnt_next = rise_load;
                        mult_cnt_next = ivfm_hiccup_mult(ov_delay_select);
                    end
                end
            end
            ST_DELAY: begin
                if (!enable) begin
                    state_next = ST_IDLE;
                end else if (!ov_fault) begin
                    state_next = ST_RUN;
                end else if (pwm_tick) begin
                    if (delay_cnt_reg <= DLY_ONE) begin
                        state_next = (ov_restart_count == RETRY_LATCH)
                                   ? ST_LATCH : ST_HICCUP;
                        rise_cnt_next = rise_load;
                        mult_cnt_next = ivfm_hiccup_mult(ov_delay_select);
                    end else begin
                        delay_cnt_next = delay_cnt_reg - 3'h1;
                    end
                end
            end
            ST_HICCUP: begin
                if (!enable) begin
                    state_next = ST_IDLE;
                end else if (rise_cnt_reg != '0) begin
                    rise_cnt_next = rise_cnt_reg - RISE_W'(1);
                end else if (mult_cnt_reg > DLY_ONE) begin
                    mult_cnt_next = mult_cnt_reg - 3'h1;
                    rise_cnt_next = rise_load;
                end else begin
                    // A restart attempt: it costs budget even when blocked.
                    if (!budget_full) budget_next = budget_reg - 3'h1;
                    if (!ov_fault) begin
                        state_next  = ST_RUN;
                        budget_next = ov_restart_count;
                    end else if (budget_full || budget_reg > 3'h1) begin
                        rise_cnt_next = rise_load;
                        mult_cnt_next = ivfm_hiccup_mult(ov_delay_select);
                    end else begin
                        state_next = ST_LATCH;
                    end
                end
            end
            ST_LATCH: begin
                if (!enable) state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            delay_cnt_reg <= '0;
            rise_cnt_reg  <= '0;
            mult_cnt_reg  <= '0;
            budget_reg    <= '0;
            pwm_last_reg  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            delay_cnt_reg <= delay_cnt_next;
            rise_cnt_reg  <= rise_cnt_next;
            mult_cnt_reg  <= mult_cnt_next;
            budget_reg    <= budget_next;
            pwm_last_reg  <= pwm_sync;
        end
    end

    // ------------------------------------------------------------------
    // Command registers, nonvolatile reload and readback
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ov_limit_reg     <= {EXP_RESET, 11'h000};
            policy_reg       <= 8'h00;
            uv_limit_reg     <= {PHASES{EXP_RESET, 11'h000}};
            load_pending_reg <= 1'b1;
        end else if (load_pending_reg || nvm_restore) begin
            ov_limit_reg     <= ivfm_round_ov({EXP_RESET, nvm_ov_mantissa});
            policy_reg       <= nvm_policy;
            uv_limit_reg     <= {PHASES{EXP_RESET, nvm_uv_mantissa}};
            load_pending_reg <= 1'b0;
        end else begin
            if (nvm_store) ov_limit_reg <= ivfm_round_ov(ov_limit_reg);
            else if (wr_ov && ov_wr_ok) ov_limit_reg <= cmd.wdata;
            if (wr_pol && pol_wr_ok) policy_reg <= cmd.wdata[7:0];
            if (wr_uv && uv_wr_ok) uv_limit_reg[cmd_phase] <= cmd.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cmd.rd;
            if (cmd.rd) begin
                case (cmd.code)
                    CMD_OV_LIMIT:    rdata_reg <= ov_limit_reg;
                    CMD_OV_RESPONSE: rdata_reg <= {8'h00, policy_reg};
                    CMD_UV_LIMIT:    rdata_reg <= phase_ok
                                     ? uv_limit_reg[cmd_phase] : 16'h0000;
                    default:         rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags; a new event wins over a clear
    // ------------------------------------------------------------------
    wire any_uv = |uv_cond;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_reg <= '0;
            uvw_reg    <= '0;
        end else begin
            status_reg.nota <= (ov_fault || any_uv)
                             || (status_reg.nota && !clear_faults);
            status_reg.input_word <= (ov_fault || any_uv)
                             || (status_reg.input_word && !clear_faults);
            status_reg.input_overvoltage_flag <= ov_fault
                || (status_reg.input_overvoltage_flag && !clear_faults);
            status_reg.invalid_data <= bad_write
                || (status_reg.invalid_data && !clear_faults);
            uvw_reg <= uv_cond | (uvw_reg & {PHASES{!clear_faults}});
        end
    end

    assign status    = status_reg;
    assign input_undervoltage_warning_flag = uvw_reg;
    assign alert_n   = !(|status_reg || |uvw_reg);
    assign switching   = (state_reg == ST_RUN) || (state_reg == ST_DELAY);
    assign latched_off = (state_reg == ST_LATCH);
    assign rsp_valid = rvalid_reg;
    assign rsp_rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_ov_flag_set: assert property (@(posedge clock) disable iff (rst)
        ov_fault |=> status.input_overvoltage_flag && !alert_n)
        else $error("overvoltage flag not set");
    a_ignore_keeps: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_RUN && enable && ov_action_select == ACT_IGNORE
        |=> switching)
        else $error("ignore response stopped switching");
    a_immediate_off: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_RUN && enable && ov_fault
        && ov_action_select == ACT_IMMEDIATE |=> !switching)
        else $error("immediate response did not shut down");
    a_latch_no_retry: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_RUN && enable && ov_fault && ov_restart_count == '0
        && ov_action_select == ACT_IMMEDIATE |=> latched_off)
        else $error("retry zero did not latch off");
    a_delay_ends: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_DELAY && enable && ov_fault && pwm_tick
        && delay_cnt_reg == DLY_ONE |=> !switching)
        else $error("delayed response did not shut down");
    a_refuse_start: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_IDLE && ov_fault |=> !switching)
        else $error("started with overvoltage present");
    a_uv_warn_set: assert property (@(posedge clock) disable iff (rst)
        uv_cond[0] |=> input_undervoltage_warning_flag[0] && status.nota)
        else $error("undervoltage warning not raised");
    a_ov_range_rej: assert property (@(posedge clock) disable iff (rst)
        wr_ov && !ov_wr_ok && !nvm_store && !nvm_restore
        && !load_pending_reg |=> $stable(ov_limit_reg) && status.invalid_data)
        else $error("bad overvoltage limit accepted");
    a_policy_rej: assert property (@(posedge clock) disable iff (rst)
        wr_pol && !pol_wr_ok && !nvm_restore && !load_pending_reg
        |=> $stable(policy_reg) && !alert_n)
        else $error("invalid response code accepted");
    a_restore_round: assert property (@(posedge clock) disable iff (rst)
        nvm_restore |=> ov_limit_exponent == EXP_RESET
        && ov_fix >= OV_MIN_FIX && ov_fix <= OV_MAX_FIX)
        else $error("restored limit not supported");
    a_budget_count: assert property (@(posedge clock) disable iff (rst)
        state_reg == ST_HICCUP && enable && rise_cnt_reg == '0
        && mult_cnt_reg <= DLY_ONE && ov_fault && !budget_full
        |=> budget_reg == $past(budget_reg) - 3'h1)
        else $error("blocked attempt not counted");
endmodule

// file: ivfm_host.sv
// Host model that drives decoded PMBus commands into the monitor.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps
module ivfm_host
    import ivfm_pkg::*;
(
    input  wire logic clock,
    output ivfm_cmd_t cmd,
    output logic [1:0] cmd_phase
);
    initial begin
        cmd       = '0;
        cmd_phase = '0;
    end
    // Holds one request for a single edge, then scrambles the idle bus.
    task automatic send(input logic w, input logic [7:0] c,
                        input logic [15:0] d, input logic [1:0] p);
        @(posedge clock);
        cmd       <= '{wr: w, rd: !w, code: c, wdata: d};
        cmd_phase <= p;
        @(posedge clock);
        cmd       <= '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
    endtask
endmodule

// file: input_voltage_fault_monitor_tb.sv
// Self-checking bench for the input voltage fault monitor.
// Assumes the host model drives commands and reads are answered in order.
`timescale 1ns/1ps
module input_voltage_fault_monitor_tb;
    import ivfm_pkg::*;
    logic              clock = 0, rst = 1, pwm_clk = 0, enable = 0;
    logic              clear_faults = 0, nvm_restore = 0, nvm_store = 0;
    logic [1:0][23:0]  power_input_voltage = {24'h800, 24'h800};
    logic [23:0]       rise_time_cycles = 24'h2;
    logic [10:0]       nvm_ov_mantissa = 11'h30, nvm_uv_mantissa = 11'h14;
    logic [7:0]        nvm_policy = 8'h00;
    logic [15:0]       rsp_rdata, expq[$];
    logic [1:0]        cmd_phase, input_undervoltage_warning_flag;
    logic              rsp_valid, switching, latched_off, alert_n;
    ivfm_cmd_t         cmd;
    ivfm_status_t      status;
    int                bad_count = 0, compares = 0, cycles = 0;
    logic [7:0]        bc[4] = '{8'h55, 8'h55, 8'h56, 8'h58};
    logic [15:0]       bw[4] = '{16'hf064, 16'he821, 16'h00c0, 16'hf040};
    ivfm_monitor i_ivfm_monitor (.clock, .rst, .pwm_clk, .cmd, .cmd_phase,
        .rsp_valid, .rsp_rdata, .power_input_voltage, .enable,
        .rise_time_cycles, .nvm_restore, .nvm_store, .nvm_ov_mantissa,
        .nvm_uv_mantissa, .nvm_policy, .clear_faults, .switching,
        .latched_off, .status, .input_undervoltage_warning_flag, .alert_n);
    ivfm_host i_ivfm_host (.clock, .cmd, .cmd_phase);
    always #10 clock = ~clock;
    always #80 pwm_clk = ~pwm_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] c, input logic [1:0] p,
                      input logic [15:0] e);
        expq.push_back(e);
        i_ivfm_host.send(1'b0, c, 16'h0, p);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic clr();
        clear_faults <= 1'b1;
        tick(1);
        clear_faults <= 1'b0;
        tick(1);
    endtask
    // Waits a bounded time for the output stage to latch off.
    task automatic wait_latch(input int n);
        for (int i = 0; i < n && latched_off !== 1'b1; i++) tick(1);
    endtask
    always @(posedge clock) begin
        if (rsp_valid === 1'b1) check(rsp_rdata, expq.pop_front());
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        logic [10:0] m;
        void'($urandom(32'h200b));
        tick(5);
        rst <= 1'b0;
        tick(3);
        clr();
        enable <= 1'b1;
        rd(8'h55, 2'h0, 16'hf030);
        rd(8'h56, 2'h0, 16'h0000);
        rd(8'h58, 2'h1, 16'hf014);
        check(switching, 1'b1);
        for (int i = 0; i < 4; i++) begin
            clr();
            i_ivfm_host.send(1'b1, bc[i], bw[i], 2'h0);
            tick(2);
            check({status.invalid_data, alert_n}, 2'b10);
        end
        rd(8'h55, 2'h0, 16'hf030);
        rd(8'h56, 2'h0, 16'h0000);
        rd(8'h58, 2'h0, 16'hf014);
        m = 11'(40 + $urandom % 41);
        i_ivfm_host.send(1'b1, 8'h55, {5'h1e, m}, 2'h0);
        rd(8'h55, 2'h0, {5'h1e, m});
        i_ivfm_host.send(1'b1, 8'h55, 16'hf030, 2'h0);
        clr();
        power_input_voltage[0] <= 24'hd00;
        tick(20);
        check({switching, status, alert_n}, 6'h3c);
        i_ivfm_host.send(1'b1, 8'h56, 16'h0080, 2'h0);
        wait_latch(20);
        check({latched_off, switching}, 2'b10);
        enable <= 1'b0;
        power_input_voltage[0] <= 24'h800;
        i_ivfm_host.send(1'b1, 8'h56, 16'h0045, 2'h0);
        enable <= 1'b1;
        tick(4);
        power_input_voltage[0] <= 24'hd00;
        tick(40);
        check(switching, 1'b1);
        wait_latch(60);
        check(latched_off, 1'b1);
        enable <= 1'b0;
        power_input_voltage[0] <= 24'h800;
        i_ivfm_host.send(1'b1, 8'h56, 16'h0092, 2'h0);
        enable <= 1'b1;
        tick(4);
        power_input_voltage[0] <= 24'hd00;
        tick(4);
        check({latched_off, switching}, 2'b00);
        wait_latch(60);
        check(latched_off, 1'b1);
        enable <= 1'b0;
        power_input_voltage[0] <= 24'h800;
        rise_time_cycles <= 24'ha;
        i_ivfm_host.send(1'b1, 8'h56, 16'h0088, 2'h0);
        enable <= 1'b1;
        tick(4);
        power_input_voltage[0] <= 24'hd00;
        tick(11);
        check({latched_off, switching}, 2'b00);
        tick(1);
        check(latched_off, 1'b1);
        enable <= 1'b0;
        power_input_voltage[0] <= 24'h800;
        i_ivfm_host.send(1'b1, 8'h56, 16'h00ba, 2'h0);
        enable <= 1'b1;
        tick(4);
        power_input_voltage[0] <= 24'hd00;
        tick(60);
        check({latched_off, switching}, 2'b00);
        power_input_voltage[0] <= 24'h800;
        tick(25);
        check(switching, 1'b1);
        power_input_voltage[0] <= 24'hd00;
        enable <= 1'b0;
        i_ivfm_host.send(1'b1, 8'h56, 16'h0000, 2'h0);
        enable <= 1'b1;
        tick(10);
        check(switching, 1'b0);
        power_input_voltage[1] <= 24'h400;
        tick(3);
        check(input_undervoltage_warning_flag, 2'b10);
        check(status.nota, 1'b1);
        power_input_voltage[0] <= 24'h400;
        tick(3);
        check(input_undervoltage_warning_flag, 2'b11);
        nvm_ov_mantissa <= 11'h60;
        nvm_restore     <= 1'b1;
        tick(1);
        nvm_restore <= 1'b0;
        nvm_store   <= 1'b1;
        tick(1);
        nvm_store <= 1'b0;
        rd(8'h55, 2'h0, 16'hf050);
        tick(2);
        check(16'(expq.size()), 16'h0000);
        give_verdict();
    end
endmodule
